// ### dst_apb_port.sv
/*
 * APB slave front end: address decode, one wait-free access phase,
 * read data and error capture.
 * Assumes an APB master that holds the request until pready.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dst_consts.svh"

module dst_apb_port
    import dst_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`DST_ADDR_W-1:0] paddr,
    input  wire dst_byte_t             rd_byte,
    output logic [4:0]                 reg_sel,
    output logic                       wr_en,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata
);
    dst_apb_state_e state_reg;
    logic           setup;

    // Address passed in, so each decode follows paddr as it changes
    function automatic logic hit(input logic [`DST_ADDR_W-1:0] a,
                                 input logic [7:0]             idx);
        hit = (a == {2'b00, idx, 2'b00});
    endfunction

    assign reg_sel[0] = hit(paddr, `DST_IDX_FIRST_LO);
    assign reg_sel[1] = hit(paddr, `DST_IDX_FIRST_HI);
    assign reg_sel[2] = hit(paddr, `DST_IDX_SECOND_LO);
    assign reg_sel[3] = hit(paddr, `DST_IDX_SECOND_HI);
    assign reg_sel[4] = hit(paddr, `DST_IDX_CONTROL);

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready && !pslverr;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= DST_APB_IDLE;
            pready    <= 1'b0;
        end else begin
            unique case (state_reg)
                DST_APB_IDLE: begin
                    if (setup) begin
                        state_reg <= DST_APB_ACCESS;
                        pready    <= 1'b1;
                    end
                end
                DST_APB_ACCESS: begin
                    state_reg <= DST_APB_IDLE;
                    pready    <= 1'b0;
                end
            endcase
        end
    end

    // Read data is the byte seen at the setup edge; no snapshot of the pair
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr <= (reg_sel == 5'h00);
        end
    end
endmodule
`default_nettype wire

// ### dst_consts.svh
/*
 * Constants of the dual system timer: register indices, control field
 * positions, reset values and widths.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef DST_CONSTS_SVH
`define DST_CONSTS_SVH

// Printed offsets are register indices; byte address is four times each
`define DST_IDX_SECOND_LO   8'hAC
`define DST_IDX_SECOND_HI   8'hAD
`define DST_IDX_FIRST_LO    8'hAE
`define DST_IDX_FIRST_HI    8'hAF
`define DST_IDX_CONTROL     8'hCF

`define DST_ADDR_W          12
`define DST_CNT_W           16
`define DST_NUM_TIMERS      2
`define DST_CTRL_RESET      8'h00
`define DST_CNT_RESET       16'h0000
`define DST_CNT_MAX         16'hFFFF

// Field offsets inside one timer's nibble of the control register
`define DST_FLD_IEN         0
`define DST_FLD_RUN         1
`define DST_FLD_MODE        2
`define DST_FLD_FLAG        3
`define DST_NIBBLE_W        4

`endif

// ### dst_counter.sv
/*
 * One 16-bit system timer: counter, reload store and byte writes.
 * Assumes one-cycle write strobes from the register file and core_clk
 * as its only count source.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dst_consts.svh"

module dst_counter
    import dst_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      resetn,
    input  wire logic      run,
    input  wire logic      reload_mode,
    input  wire logic      wr_lo,
    input  wire logic      wr_hi,
    input  wire dst_byte_t wdata,
    output dst_count_t     count,
    output logic           wrap
);
    dst_count_t count_reg;
    dst_count_t reload_reg;
    logic       load_cnt;

    assign load_cnt = !reload_mode && (wr_lo || wr_hi);
    // A counter load beats the increment and cancels a coinciding wrap
    assign wrap     = run && !load_cnt && (count_reg == `DST_CNT_MAX);
    assign count    = count_reg;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= `DST_CNT_RESET;
        end else if (load_cnt) begin
            if (wr_lo) begin
                count_reg[7:0] <= wdata;
            end
            if (wr_hi) begin
                count_reg[15:8] <= wdata;
            end
        end else if (wrap) begin
            count_reg <= reload_mode ? reload_reg : `DST_CNT_RESET;
        end else if (run) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reload_reg <= `DST_CNT_RESET;
        end else if (reload_mode) begin
            if (wr_lo) begin
                reload_reg[7:0] <= wdata;
            end
            if (wr_hi) begin
                reload_reg[15:8] <= wdata;
            end
        end
    end

    a_halt_holds: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (!run && !load_cnt) |=> (count_reg == $past(count_reg)))
        else $error("stopped counter moved");

    a_count_step: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (run && !load_cnt && count_reg != `DST_CNT_MAX)
        |=> (count_reg == $past(count_reg) + 16'h0001))
        else $error("running counter did not step by one");

    a_reload_wrap: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (wrap && reload_mode) |=> (count_reg == $past(reload_reg)))
        else $error("reload value not taken on overflow");

    a_free_wrap: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (wrap && !reload_mode) |=> (count_reg == `DST_CNT_RESET))
        else $error("free-run counter did not wrap to zero");

    a_reload_store: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (reload_mode && wr_hi)
        |=> (reload_reg[15:8] == $past(wdata)) && (count_reg[15:8]
            != $past(wdata) || $past(count_reg[15:8]) == $past(wdata)
            || $past(run)))
        else $error("reload-mode write missed reload store or hit count");

    a_free_load: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (!reload_mode && wr_lo) |=> (count_reg[7:0] == $past(wdata)))
        else $error("free-run write did not load the counter");
endmodule
`default_nettype wire

// ### dst_pkg.sv
/*
 * Types shared by the dual system timer modules.
 * Assumes dst_consts.svh is on the include path.
 */
`default_nettype none
`include "dst_consts.svh"

package dst_pkg;
    typedef logic [7:0] dst_byte_t;
    typedef logic [`DST_CNT_W-1:0] dst_count_t;
    typedef enum logic {DST_APB_IDLE, DST_APB_ACCESS} dst_apb_state_e;
endpackage
`default_nettype wire

// ### dst_timer_pair.sv
/*
 * Dual 16-bit system timer with shared control register over APB.
 * Assumes one clock, core_clk at 250 MHz, asynchronous active-low resetn,
 * and an APB master on the register side.
 */
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dst_consts.svh"

module dst_timer_pair
    import dst_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`DST_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    output logic                        first_irq,
    output logic                        second_irq
);
    localparam int NT = `DST_NUM_TIMERS;

    logic [4:0]  reg_sel;
    logic        wr_en;
    dst_byte_t   rd_byte;
    dst_byte_t   wbyte;
    dst_byte_t   ctrl_reg;
    dst_count_t  count_w [NT];
    logic [NT-1:0] wrap_w;
    logic [NT-1:0] irq_reg;
    logic        ctrl_wr;

    assign wbyte   = pwdata[7:0];
    assign ctrl_wr = wr_en && reg_sel[4];

    dst_apb_port u_apb (
        .core_clk (core_clk),
        .resetn   (resetn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .rd_byte  (rd_byte),
        .reg_sel  (reg_sel),
        .wr_en    (wr_en),
        .pready   (pready),
        .pslverr  (pslverr),
        .prdata   (prdata)
    );

    // Timer i owns control nibble i and byte registers 2i (low), 2i+1 (high)
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_timer
            localparam int B = gi * `DST_NIBBLE_W;
            dst_counter u_cnt (
                .core_clk    (core_clk),
                .resetn      (resetn),
                .run         (ctrl_reg[B + `DST_FLD_RUN]),
                .reload_mode (ctrl_reg[B + `DST_FLD_MODE]),
                .wr_lo       (wr_en && reg_sel[2*gi]),
                .wr_hi       (wr_en && reg_sel[2*gi + 1]),
                .wdata       (wbyte),
                .count       (count_w[gi]),
                .wrap        (wrap_w[gi])
            );
        end
    endgenerate

    // Overflow set wins over a software clear in the same cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= `DST_CTRL_RESET;
        end else begin
            for (int i = 0; i < NT; i++) begin
                if (ctrl_wr) begin
                    ctrl_reg[i*4 +: 3] <= wbyte[i*4 +: 3];
                end
                if (wrap_w[i]) begin
                    ctrl_reg[i*4 + `DST_FLD_FLAG] <= 1'b1;
                end else if (ctrl_wr) begin
                    ctrl_reg[i*4 + `DST_FLD_FLAG] <=
                        wbyte[i*4 + `DST_FLD_FLAG];
                end
            end
        end
    end

    // Request follows flag and enable one cycle late, from a flop
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_reg <= '0;
        end else begin
            for (int i = 0; i < NT; i++) begin
                irq_reg[i] <= ctrl_reg[i*4 + `DST_FLD_FLAG]
                    && ctrl_reg[i*4 + `DST_FLD_IEN];
            end
        end
    end

    assign first_irq  = irq_reg[0];
    assign second_irq = irq_reg[1];

    // Live count bytes; the pair is not coherent across two reads
    always_comb begin
        rd_byte = 8'h00;
        unique case (1'b1)
            reg_sel[0]: rd_byte = count_w[0][7:0];
            reg_sel[1]: rd_byte = count_w[0][15:8];
            reg_sel[2]: rd_byte = count_w[1][7:0];
            reg_sel[3]: rd_byte = count_w[1][15:8];
            reg_sel[4]: rd_byte = ctrl_reg;
            default:    rd_byte = 8'h00;
        endcase
    end

    a_flag_sets: assert property (
        @(posedge core_clk) disable iff (!resetn)
        wrap_w[0] |=> ctrl_reg[`DST_FLD_FLAG] [*2] or
        (ctrl_reg[`DST_FLD_FLAG] ##1 1'b1))
        else $error("first overflow flag not set");

    a_flag_sticky: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (ctrl_reg[4 + `DST_FLD_FLAG] && !ctrl_wr)
        |=> ctrl_reg[4 + `DST_FLD_FLAG])
        else $error("second overflow flag dropped without a write");

    a_irq_gate: assert property (
        @(posedge core_clk) disable iff (!resetn)
        ##1 (first_irq == $past(ctrl_reg[`DST_FLD_FLAG]
            && ctrl_reg[`DST_FLD_IEN])))
        else $error("first interrupt not gated by flag and enable");

    a_read_live: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (psel && !penable && !pwrite && reg_sel[3])
        |=> (prdata[7:0] == $past(count_w[1][15:8])) && pready)
        else $error("high byte read did not return live count");

    a_unmapped_err: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (psel && !penable && reg_sel == 5'h00) |=> (pslverr && pready))
        else $error("unmapped access not flagged");

    a_second_sets: assert property (
        @(posedge core_clk) disable iff (!resetn)
        wrap_w[1] |=> ctrl_reg[4 + `DST_FLD_FLAG])
        else $error("second overflow flag not set");

    a_flag_clear: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (ctrl_wr && !wrap_w[0])
        |=> (ctrl_reg[`DST_FLD_FLAG] == $past(wbyte[`DST_FLD_FLAG])))
        else $error("first overflow flag did not take the written value");

    a_ctrl_fields: assert property (
        @(posedge core_clk) disable iff (!resetn)
        ctrl_wr |=> (ctrl_reg[6:4] == $past(wbyte[6:4]))
            && (ctrl_reg[2:0] == $past(wbyte[2:0])))
        else $error("control fields did not take the written value");

    a_fields_hold: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !ctrl_wr |=> (ctrl_reg[6:4] == $past(ctrl_reg[6:4]))
            && (ctrl_reg[2:0] == $past(ctrl_reg[2:0])))
        else $error("control fields changed without a write");

    a_second_gate: assert property (
        @(posedge core_clk) disable iff (!resetn)
        ##1 (second_irq == $past(ctrl_reg[4 + `DST_FLD_FLAG]
            && ctrl_reg[4 + `DST_FLD_IEN])))
        else $error("second interrupt not gated by flag and enable");

    a_read_first_lo: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (psel && !penable && !pwrite && reg_sel[0])
        |=> (prdata[7:0] == $past(count_w[0][7:0])) && pready)
        else $error("low byte read did not return live count");

    // No wait states: ready stands for the access cycle only
    a_ready_pulse: assert property (
        @(posedge core_clk) disable iff (!resetn)
        pready |=> !pready)
        else $error("ready stood longer than one cycle");
endmodule
`default_nettype wire

// ### testbench.sv
/*
 * Self-checking bench for the dual system timer: APB read and write
 * tasks, then per-timer sequences with expected register values.
 * Assumes dst_consts.svh on the include path and dst_pkg compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dst_consts.svh"

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("BAD %s expected %h seen %h", nm, exp, got); \
    end end

module testbench
    import dst_pkg::*;
;
    // Byte address is four times the register index
    localparam logic [11:0] A_S_LO = {2'h0, `DST_IDX_SECOND_LO, 2'h0};
    localparam logic [11:0] A_S_HI = {2'h0, `DST_IDX_SECOND_HI, 2'h0};
    localparam logic [11:0] A_F_LO = {2'h0, `DST_IDX_FIRST_LO, 2'h0};
    localparam logic [11:0] A_F_HI = {2'h0, `DST_IDX_FIRST_HI, 2'h0};
    localparam logic [11:0] A_CTRL = {2'h0, `DST_IDX_CONTROL, 2'h0};

    logic        core_clk = 1'h0;
    logic        resetn   = 1'h0;
    logic        psel     = 1'h0;
    logic        penable  = 1'h0;
    logic        pwrite   = 1'h0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h00000000;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        first_irq;
    logic        second_irq;
    logic [1:0]  irqs;
    int          n_mismatch = 0;
    int          n_checks   = 0;

    assign irqs = {second_irq, first_irq};

    always #2 core_clk = ~core_clk;

    dst_timer_pair dst_timer_pair_i (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .pready     (pready),
        .prdata     (prdata),
        .pslverr    (pslverr),
        .first_irq  (first_irq),
        .second_irq (second_irq)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Idle edge first, so no signal is assigned twice in one step
    task automatic xfer(input logic w, input logic [11:0] a,
                        input dst_byte_t d, output dst_byte_t q,
                        output logic e);
        @(posedge core_clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'h1;
        // Read before the edge's updates: what the slave sees at this edge
        do begin
            @(posedge core_clk);
        end while (pready !== 1'h1);
        q = prdata[7:0];
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [11:0] a, input dst_byte_t d);
        dst_byte_t q;
        logic      e;
        xfer(1'h1, a, d, q, e);
    endtask

    task automatic chk_rd(input logic [11:0] a, input dst_byte_t exp,
                          input string nm);
        dst_byte_t q;
        logic      e;
        xfer(1'h0, a, 8'h00, q, e);
        `CHK(nm, exp, q)
        `CHK("read err", 1'h0, e)
    endtask

    task automatic chk_irq(input int t, input logic exp);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("irq", exp, irqs[t])
        `CHK("other irq", 1'h0, irqs[1-t])
    endtask

    function automatic dst_byte_t place(input int t, input logic [3:0] nib);
        return (t != 0) ? {nib, 4'h0} : {4'h0, nib};
    endfunction

    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        dst_byte_t     q;
        logic          e;
        logic [11:0]   lo;
        logic [11:0]   hi;
        repeat (6) @(posedge core_clk);
        resetn <= 1'h1;
        chk_rd(A_S_LO, 8'h00, "second lo reset");
        chk_rd(A_S_HI, 8'h00, "second hi reset");
        chk_rd(A_F_LO, 8'h00, "first lo reset");
        chk_rd(A_F_HI, 8'h00, "first hi reset");
        chk_rd(A_CTRL, `DST_CTRL_RESET, "control reset");
        xfer(1'h0, 12'h000, 8'h00, q, e);
        `CHK("unmapped err", 1'h1, e)
        `CHK("unmapped data", 8'h00, q)
        wr(12'h000, 8'hFF);
        chk_rd(A_CTRL, 8'h00, "control after unmapped write");
        $display("reset and decode test done");
        for (int t = 0; t < 2; t++) begin
            lo = (t != 0) ? A_S_LO : A_F_LO;
            hi = (t != 0) ? A_S_HI : A_F_HI;
            wr(lo, 8'hFA);
            wr(hi, 8'hFF);
            chk_rd(hi, 8'hFF, "free-run load hi");
            chk_rd(lo, 8'hFA, "free-run load lo");
            repeat (8) @(posedge core_clk);
            chk_rd(lo, 8'hFA, "halted lo");
            wr(A_CTRL, place(t, 4'h3));
            repeat (20) @(posedge core_clk);
            chk_rd(A_CTRL, place(t, 4'hB), "flag after wrap");
            chk_irq(t, 1'h1);
            wr(A_CTRL, place(t, 4'h1));
            chk_rd(hi, 8'h00, "free-run wrap hi");
            chk_rd(A_CTRL, place(t, 4'h1), "flag cleared");
            chk_irq(t, 1'h0);
            wr(A_CTRL, place(t, 4'h8));
            chk_irq(t, 1'h0);
            wr(A_CTRL, place(t, 4'h9));
            chk_irq(t, 1'h1);
            wr(A_CTRL, place(t, 4'h0));
            wr(lo, 8'hF8);
            wr(hi, 8'hFF);
            wr(A_CTRL, place(t, 4'h4));
            wr(lo, 8'h80);
            wr(hi, 8'h12);
            chk_rd(hi, 8'hFF, "reload write keeps count hi");
            chk_rd(lo, 8'hF8, "reload write keeps count lo");
            wr(A_CTRL, place(t, 4'h6));
            repeat (20) @(posedge core_clk);
            chk_rd(A_CTRL, place(t, 4'hE), "reload flag");
            chk_irq(t, 1'h0);
            wr(A_CTRL, place(t, 4'h4));
            chk_rd(hi, 8'h12, "reloaded count hi");
            wr(A_CTRL, 8'h00);
            $display("timer %0d test done", t);
        end
        complete_run();
    end
endmodule

`default_nettype wire
